// *** lerr_map.svh ***
// register map, field positions and reset values of the error routing block
`ifndef LERR_MAP_SVH
`define LERR_MAP_SVH
// register indices; byte address is four times the index
`define LERR_IDX_SCRATCH 6'h10
`define LERR_IDX_CTL 6'h12
`define LERR_IDX_BASE_UP 6'h14
`define LERR_IDX_LIMIT_UP 6'h15
`define LERR_IDX_BUS_NUM 6'h1a
// routing control fields
`define LERR_BIT_PROT_FLOOD 0
`define LERR_BIT_OVFL_FLOOD 1
`define LERR_FATAL_LO 2
`define LERR_BIT_SYS_FATAL 7
`define LERR_BIT_CHAIN_FAIL 8
`define LERR_BIT_RESP_ERR 9
`define LERR_NONFATAL_LO 10
`define LERR_BIT_SYS_NONFATAL 15
// link error log byte positions
`define LERR_LOG_PROT 4
`define LERR_LOG_OVFL 5
`define LERR_LOG_EOC 6
`define LERR_LOG_CTL_TIME 7
// reset values
`define LERR_RST_SCRATCH 16'h0000
`define LERR_RST_EN 16'h0000
`define LERR_RST_BYTE 8'h00
`define LERR_RST_BUS 8'h00
`endif

// *** lerr_pkg.sv ***
// types shared by the error routing register block
package lerr_pkg;
  typedef logic [15:0] lerr_word_t;
  typedef logic [7:0] lerr_byte_t;
  // error sources in routing order, fatal enable = 2 + index
  typedef enum logic [2:0] {
    LERR_SRC_PROT,
    LERR_SRC_OVFL,
    LERR_SRC_EOC,
    LERR_SRC_RESP,
    LERR_SRC_CRC,
    LERR_SRC_SYS
  } lerr_src_t;
endpackage

// *** lerr_route_if.sv ***
// carrier between the register bank and the interrupt/flood router
`timescale 1ns/1ps
interface lerr_route_if;
  logic [15:0] en;
  logic [5:0] src;
  logic flood_qual;
  logic fatal;
  logic nonfatal;
  logic flood;
  modport regs (output en, output src, output flood_qual,
                input fatal, input nonfatal, input flood);
  modport route (input en, input src, input flood_qual,
                 output fatal, output nonfatal, output flood);
endinterface

// *** lerr_route.sv ***
// routes error log bits through enables onto interrupts and sync flood
`timescale 1ns/1ps
module lerr_route
  import lerr_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  lerr_route_if.route rif
);
  `include "lerr_map.svh"

  logic fatal_ff;
  logic nonfatal_ff;
  logic flood_ff;
  logic nxt_fatal;
  logic nxt_nonfatal;
  logic nxt_flood;

  // or of every source anded with its own enable
  always_comb begin
    nxt_fatal =
      |(rif.src & rif.en[`LERR_BIT_SYS_FATAL:`LERR_FATAL_LO]);
    nxt_nonfatal =
      |(rif.src & rif.en[`LERR_BIT_SYS_NONFATAL:`LERR_NONFATAL_LO]);
    nxt_flood = rif.flood_qual &
      ((rif.src[LERR_SRC_PROT] & rif.en[`LERR_BIT_PROT_FLOOD]) |
       (rif.src[LERR_SRC_OVFL] & rif.en[`LERR_BIT_OVFL_FLOOD]));
  end

  // registered so the top drives its pins from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fatal_ff <= 1'b0;
      nonfatal_ff <= 1'b0;
      flood_ff <= 1'b0;
    end else begin
      fatal_ff <= nxt_fatal;
      nonfatal_ff <= nxt_nonfatal;
      flood_ff <= nxt_flood;
    end
  end

  assign rif.fatal = fatal_ff;
  assign rif.nonfatal = nonfatal_ff;
  assign rif.flood = flood_ff;

  // route checks share one clock and the combined reset
  default clocking route_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_prot_fatal_route: assert property (
    rif.src[0] && rif.en[2] |=> fatal_ff) else $error("prot fatal lost");
  a_ovfl_nf_route: assert property (
    rif.src[1] && rif.en[11] |=> nonfatal_ff) else $error("ovfl nf lost");
  a_crc_fatal_route: assert property (
    rif.src[4] && rif.en[6] |=> fatal_ff) else $error("crc fatal lost");
  a_no_cause_quiet: assert property (
    (rif.src & rif.en[15:10]) == 6'h00 |=> !nonfatal_ff)
    else $error("nonfatal without cause");
endmodule

// *** lerr_regs.sv ***
// error routing register bank with classic wishbone slave
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
// Summary of operation
// - protocol log floods when enabled and qualified
// - overflow log floods when enabled and qualified
// - chain reset leaves flood enables untouched
// - protocol log routes via enables 2, 10
// - overflow log routes via enables 3, 11
// - end-of-chain or inbound routes via 4, 12
// - response error routes via enables 5, 13
// - link crc errors route via 6, 14
// - host system error routes via 7, 15
// - system error enables zero on slaves
// - missing interrupt forces its enables zero
// - unchecked conditions: log and enables zero
// - chain fail sticky, cleared by chain reset
// - response error set, read clears, cold resets
// - routing enables read/write, warm reset zero
// - scratchpad plain read/write, cold reset zero
// - upper base byte extends base to 40
// - upper limit byte extends limit to 40
// - shared primary applies its extension to all
// - secondary uses primary values if link primary
// - 64-bit remap present makes extensions reserved
// - bus number captured from type 0 writes
// - log bits at 4..7 of their byte
module lerr_regs
  import lerr_pkg::*;
#(
  parameter bit IS_HOST = 1'b0,
  parameter bit FATAL_IMPL = 1'b1,
  parameter bit NONFATAL_IMPL = 1'b1,
  parameter logic [5:0] CHECKED = 6'h3f,
  parameter bit REMAP64 = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cold_rst_i,
  input wire logic chain_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] link_err_log_i,
  input wire logic inb_eoc_err_i,
  input wire logic crc_err_i,
  input wire logic sys_err_det_i,
  input wire logic system_error_report_en_i,
  input wire logic resp_err_rcvd_i,
  input wire logic sync_flood_det_i,
  input wire logic cfg_type0_wr_i,
  input wire logic [7:0] cfg_bus_num_i,
  input wire logic use_primary_ext_i,
  input wire logic [7:0] prim_base_upper_i,
  input wire logic [7:0] prim_limit_upper_i,
  output logic flood_o,
  output logic fatal_int_o,
  output logic nonfatal_int_o,
  output logic chain_fail_o,
  output logic [7:0] mem_base_upper_o,
  output logic [7:0] mem_limit_upper_o,
  output logic [7:0] bus_num_o
);
  `include "lerr_map.svh"

  // per-source enable availability, six sources in routing order
  localparam logic [5:0] SRC_OK = CHECKED & {IS_HOST, 5'h1f};
  localparam logic [15:0] EN_MASK = {
    SRC_OK & {6{NONFATAL_IMPL}},
    2'b00,
    SRC_OK & {6{FATAL_IMPL}},
    SRC_OK[1:0]};

  // merge byte lanes of a 16-bit register
  function automatic lerr_word_t lane_merge(input lerr_word_t old_v,
      input lerr_word_t new_v, input logic [1:0] sel);
    lane_merge = {sel[1] ? new_v[15:8] : old_v[15:8],
                  sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction

  lerr_route_if rif ();

  logic acc;
  logic wr;
  logic rd;
  logic [5:0] idx;
  lerr_word_t scratch_ff;
  lerr_word_t en_ff;
  logic chain_fail_ff;
  logic resp_err_ff;
  lerr_byte_t base_ff;
  lerr_byte_t limit_ff;
  lerr_byte_t bus_ff;
  logic ack_ff;
  logic [31:0] dat_ff;
  lerr_byte_t base_out_ff;
  lerr_byte_t limit_out_ff;
  logic [31:0] nxt_dat;
  lerr_word_t ctl_view;
  logic [5:0] src;
  logic flood_cause;

  // one access per request; ack drops the cycle after it rose
  assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr = acc & wb_we_i;
  assign rd = acc & ~wb_we_i;
  assign idx = wb_adr_i[7:2];

  // log bits masked where the condition is not checked
  always_comb begin
    src = 6'h00;
    src[LERR_SRC_PROT] = link_err_log_i[`LERR_LOG_PROT];
    src[LERR_SRC_OVFL] = link_err_log_i[`LERR_LOG_OVFL];
    src[LERR_SRC_EOC] = link_err_log_i[`LERR_LOG_EOC] | inb_eoc_err_i;
    src[LERR_SRC_RESP] = resp_err_ff;
    src[LERR_SRC_CRC] = crc_err_i;
    src[LERR_SRC_SYS] = sys_err_det_i;
    src = src & CHECKED;
  end

  assign rif.src = src;
  assign rif.en = en_ff;
  // slaves also need the system error report enable
  assign rif.flood_qual = IS_HOST | system_error_report_en_i;

  lerr_route u_route (
    .clk_i(clk_i),
    .rst_i(rst_i | cold_rst_i),
    .rif(rif)
  );

  // an error that would flood marks the chain failed at once
  assign flood_cause = rif.flood_qual &
    ((src[LERR_SRC_PROT] & en_ff[`LERR_BIT_PROT_FLOOD]) |
     (src[LERR_SRC_OVFL] & en_ff[`LERR_BIT_OVFL_FLOOD]));

  // scratchpad, survives warm reset
  always_ff @(posedge clk_i) begin
    if (cold_rst_i) begin
      scratch_ff <= `LERR_RST_SCRATCH;
    end else if (wr && idx == `LERR_IDX_SCRATCH) begin
      scratch_ff <= lane_merge(scratch_ff, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
  end

  // routing enables; chain reset deliberately not here so software
  // must clear flood enables itself to stop flooding recurring
  always_ff @(posedge clk_i) begin
    if (rst_i || cold_rst_i) begin
      en_ff <= `LERR_RST_EN;
    end else if (wr && idx == `LERR_IDX_CTL) begin
      en_ff <= lane_merge(en_ff, wb_dat_i[15:0], wb_sel_i[1:0]) &
        EN_MASK;
    end
  end

  // chain fail: sticky until the failed chain is reset
  always_ff @(posedge clk_i) begin
    if (rst_i || cold_rst_i || chain_rst_i) begin
      chain_fail_ff <= 1'b0;
    end else if (sync_flood_det_i || flood_cause) begin
      chain_fail_ff <= 1'b1;
    end
  end

  // response error: new event wins over read-clear
  always_ff @(posedge clk_i) begin
    if (cold_rst_i) begin
      resp_err_ff <= 1'b0;
    end else if (resp_err_rcvd_i && CHECKED[LERR_SRC_RESP]) begin
      resp_err_ff <= 1'b1;
    end else if (rd && idx == `LERR_IDX_CTL && wb_sel_i[1]) begin
      resp_err_ff <= 1'b0;
    end
  end

  // upper address bytes; reserved when 64-bit remap exists
  always_ff @(posedge clk_i) begin
    if (rst_i || cold_rst_i || REMAP64) begin
      base_ff <= `LERR_RST_BYTE;
      limit_ff <= `LERR_RST_BYTE;
    end else if (wr && wb_sel_i[0]) begin
      if (idx == `LERR_IDX_BASE_UP) begin
        base_ff <= wb_dat_i[7:0];
      end
      if (idx == `LERR_IDX_LIMIT_UP) begin
        limit_ff <= wb_dat_i[7:0];
      end
    end
  end

  // decoder extension: primary block's values win when selected
  always_ff @(posedge clk_i) begin
    if (rst_i || cold_rst_i || REMAP64) begin
      base_out_ff <= `LERR_RST_BYTE;
      limit_out_ff <= `LERR_RST_BYTE;
    end else if (use_primary_ext_i) begin
      base_out_ff <= prim_base_upper_i;
      limit_out_ff <= prim_limit_upper_i;
    end else begin
      base_out_ff <= base_ff;
      limit_out_ff <= limit_ff;
    end
  end

  // bus number, software cannot write it
  always_ff @(posedge clk_i) begin
    if (rst_i || cold_rst_i) begin
      bus_ff <= `LERR_RST_BUS;
    end else if (cfg_type0_wr_i) begin
      bus_ff <= cfg_bus_num_i;
    end
  end

  assign ctl_view = {en_ff[15:10], resp_err_ff, chain_fail_ff,
                     en_ff[7:0]};

  // read mux; unmapped words read zero and still ack
  always_comb begin
    nxt_dat = 32'h0000_0000;
    unique case (idx)
      `LERR_IDX_SCRATCH: nxt_dat[15:0] = scratch_ff;
      `LERR_IDX_CTL: nxt_dat[15:0] = ctl_view;
      `LERR_IDX_BASE_UP: nxt_dat[7:0] = base_ff;
      `LERR_IDX_LIMIT_UP: nxt_dat[7:0] = limit_ff;
      `LERR_IDX_BUS_NUM: nxt_dat[7:0] = bus_ff;
      default: nxt_dat = 32'h0000_0000;
    endcase
  end

  // bus answer: ack one cycle after the request is seen
  always_ff @(posedge clk_i) begin
    if (rst_i || cold_rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= acc;
      dat_ff <= rd ? nxt_dat : 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign flood_o = rif.flood;
  assign fatal_int_o = rif.fatal;
  assign nonfatal_int_o = rif.nonfatal;
  assign chain_fail_o = chain_fail_ff;
  assign mem_base_upper_o = base_out_ff;
  assign mem_limit_upper_o = limit_out_ff;
  assign bus_num_o = bus_ff;

  // checks, warm and cold reset both disable all but a_enables_warm
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || cold_rst_i);

  sequence prot_flood_s;
    src[0] && en_ff[0] && rif.flood_qual;
  endsequence
  sequence ovfl_flood_s;
    src[1] && en_ff[1] && rif.flood_qual;
  endsequence
  sequence ctl_read_s;
    rd && idx == `LERR_IDX_CTL && wb_sel_i[1] && !resp_err_rcvd_i;
  endsequence

  // flood follows its cause one edge later, through the route register
  a_prot_flood_out: assert property (prot_flood_s |=> flood_o)
    else $error("protocol flood missing");
  a_ovfl_flood_out: assert property (ovfl_flood_s |=> flood_o)
    else $error("overflow flood missing");
  a_flood_unqual: assert property (!rif.flood_qual |=> !flood_o)
    else $error("flood without qualifier");
  a_resp_err_set: assert property (
    resp_err_rcvd_i && CHECKED[3] |=> resp_err_ff)
    else $error("response error not set");
  a_resp_err_rdclr: assert property (ctl_read_s |=> !resp_err_ff)
    else $error("response error not cleared");
  a_chain_fail_hold: assert property (
    chain_fail_ff && !chain_rst_i |=> chain_fail_ff)
    else $error("chain fail lost");
  a_chain_fail_set: assert property (
    sync_flood_det_i && !chain_rst_i |=> chain_fail_o)
    else $error("chain fail not set");
  a_chain_fail_cause: assert property (
    flood_cause && !chain_rst_i |=> chain_fail_o)
    else $error("flood cause did not fail chain");
  a_flood_en_keep: assert property (
    chain_rst_i && !wr |=> en_ff[1:0] == $past(en_ff[1:0]))
    else $error("chain reset cleared flood enable");
  a_enables_warm: assert property (disable iff (1'b0)
    rst_i |=> en_ff == 16'h0000)
    else $error("enables not cleared");
  a_en_masked: assert property ((en_ff & ~EN_MASK) == 16'h0000)
    else $error("unimplemented enable set");
  a_scratch_stable: assert property (
    !(wr && idx == `LERR_IDX_SCRATCH) |=> $stable(scratch_ff))
    else $error("scratchpad changed");
  a_slave_sys_zero: assert property (
    !IS_HOST |-> !en_ff[7] && !en_ff[15])
    else $error("slave system enable set");
  a_base_write: assert property (
    wr && wb_sel_i[0] && idx == `LERR_IDX_BASE_UP && !REMAP64 |=>
      base_ff == $past(wb_dat_i[7:0]))
    else $error("upper base byte not written");
  a_limit_write: assert property (
    wr && wb_sel_i[0] && idx == `LERR_IDX_LIMIT_UP && !REMAP64 |=>
      limit_ff == $past(wb_dat_i[7:0]))
    else $error("upper limit byte not written");
  a_bus_capture: assert property (
    cfg_type0_wr_i |=> bus_num_o == $past(cfg_bus_num_i))
    else $error("bus number not captured");
  a_bus_readonly: assert property (
    wr && idx == `LERR_IDX_BUS_NUM && !cfg_type0_wr_i |=> $stable(bus_ff))
    else $error("bus number written by software");
  a_ext_primary: assert property (
    use_primary_ext_i && !REMAP64 |=>
      mem_base_upper_o == $past(prim_base_upper_i))
    else $error("primary extension not used");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  // every remaining route pair except the system error ones (enables 7, 15), checked at the pins
  a_prot_nf_out: assert property (
    src[0] && en_ff[10] |=> nonfatal_int_o)
    else $error("protocol nonfatal missing");
  a_ovfl_fatal_out: assert property (
    src[1] && en_ff[3] |=> fatal_int_o)
    else $error("overflow fatal missing");
  a_eoc_fatal_out: assert property (
    src[2] && en_ff[4] |=> fatal_int_o)
    else $error("end of chain fatal missing");
  a_eoc_nf_route: assert property (
    inb_eoc_err_i && CHECKED[2] && en_ff[12] |=> nonfatal_int_o)
    else $error("end of chain nonfatal missing");
  a_resp_fatal_out: assert property (
    src[3] && en_ff[5] |=> fatal_int_o)
    else $error("response fatal missing");
  a_resp_nf_out: assert property (
    src[3] && en_ff[13] |=> nonfatal_int_o)
    else $error("response nonfatal missing");
  a_crc_nf_out: assert property (
    src[4] && en_ff[14] |=> nonfatal_int_o)
    else $error("crc nonfatal missing");
  a_fatal_quiet: assert property (
    (src & en_ff[7:2]) == 6'h00 |=> !fatal_int_o)
    else $error("fatal without cause");
endmodule

// *** lerr_link_model.sv ***
// far-side link error logic model feeding the error routing block
`timescale 1ns/1ps
module lerr_link_model (
  input wire logic clk_i,
  input wire logic [5:0] cmd_i,
  output logic [7:0] link_err_log_o,
  output logic inb_eoc_err_o,
  output logic crc_err_o,
  output logic sys_err_det_o
);
  logic [3:0] noise_ff = 4'h0;

  // low nibble belongs to another field, churns to expose misuse
  always_ff @(posedge clk_i) begin
    noise_ff <= noise_ff + 4'h1;
  end

  // log bits in 7:4, timeout select held low
  assign link_err_log_o = {1'b0, cmd_i[2:0], noise_ff};
  assign inb_eoc_err_o = cmd_i[3];
  assign crc_err_o = cmd_i[4];
  assign sys_err_det_o = cmd_i[5];
endmodule

// *** lerr_regs_tb.sv ***
// self-checking bench for the error routing register block
`timescale 1ns/1ps
module lerr_regs_tb;
  import lerr_pkg::*;
  logic clk_i = 1'b0;
  logic rst = 1'b1, cold = 1'b1, chain = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [5:0] cmd = 6'h00;
  logic rep_en = 1'b0, resp = 1'b0, sflood = 1'b0, cfgwr = 1'b0;
  logic useprim = 1'b0;
  logic [7:0] cfgbus = 8'h00, pbase = 8'h00, plimit = 8'h00;
  logic [7:0] log_b, base_o, limit_o, bus_o;
  logic ieoc, crc, sysd, flood, fatal, nfatal, cfail;
  logic [3:0] sel = 4'h3;
  logic [3:0] lanes = 4'h3;
  int fails = 0;
  int checks = 0;

  lerr_link_model link_u (.clk_i(clk_i), .cmd_i(cmd),
    .link_err_log_o(log_b), .inb_eoc_err_o(ieoc), .crc_err_o(crc),
    .sys_err_det_o(sysd));

  lerr_regs dut_u (.clk_i(clk_i), .rst_i(rst), .cold_rst_i(cold),
    .chain_rst_i(chain), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .link_err_log_i(log_b), .inb_eoc_err_i(ieoc),
    .crc_err_i(crc), .sys_err_det_i(sysd),
    .system_error_report_en_i(rep_en), .resp_err_rcvd_i(resp),
    .sync_flood_det_i(sflood), .cfg_type0_wr_i(cfgwr),
    .cfg_bus_num_i(cfgbus), .use_primary_ext_i(useprim),
    .prim_base_upper_i(pbase), .prim_limit_upper_i(plimit),
    .flood_o(flood), .fatal_int_o(fatal), .nonfatal_int_o(nfatal),
    .chain_fail_o(cfail), .mem_base_upper_o(base_o),
    .mem_limit_upper_o(limit_o), .bus_num_o(bus_o));

  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic final_report;
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input lerr_word_t seen,
                     input lerr_word_t exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask

  // one classic cycle; holds until ack is seen at a rising edge
  task automatic acc(input logic w, input logic [7:0] a,
                     input lerr_word_t d, output lerr_word_t r);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lanes;
    wdat <= {16'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input lerr_word_t d);
    lerr_word_t r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rdc(input string n, input logic [7:0] a,
                     input lerr_word_t e);
    lerr_word_t r;
    acc(1'b0, a, 16'h0, r);
    chk(n, r, e);
  endtask

  // inputs reach the pins one edge later; three leave margin
  task automatic w3;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic pulse_reset(input logic is_cold);
    @(posedge clk_i);
    rst <= 1'b1;
    cold <= is_cold;
    repeat (2) @(posedge clk_i);
    rst <= 1'b0;
    cold <= 1'b0;
  endtask

  // hang guard, generous against the couple of hundred cycles used
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    final_report();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst <= 1'b0;
    cold <= 1'b0;
    rdc("ctl_rst", 8'h48, 16'h0000);
    rdc("scr_rst", 8'h40, 16'h0000);
    rdc("bus_rst", 8'h68, 16'h0000);
    // all fatal and nonfatal enables; slave drops the system ones
    wr(8'h48, 16'hfffc);
    rdc("ctl_en", 8'h48, 16'h7c7c);
    // each source alone: prot, ovfl, eoc, inbound eoc, crc, sys
    for (int i = 0; i < 6; i++) begin
      cmd <= 6'h01 << i;
      w3();
      chk("fatal_src", {15'h0, fatal}, {15'h0, i != 5});
      chk("nfatal_src", {15'h0, nfatal}, {15'h0, i != 5});
      cmd <= 6'h00;
      w3();
      chk("fatal_off", {15'h0, fatal}, 16'h0000);
    end
    // response error routes, read clears it
    resp <= 1'b1;
    @(posedge clk_i);
    resp <= 1'b0;
    w3();
    chk("fatal_resp", {15'h0, fatal}, 16'h0001);
    rdc("ctl_resp", 8'h48, 16'h7e7c);
    rdc("ctl_clr", 8'h48, 16'h7c7c);
    w3();
    chk("fatal_resp0", {15'h0, fatal}, 16'h0000);
    // nonfatal path only
    wr(8'h48, 16'h0400);
    cmd <= 6'h01;
    w3();
    chk("split_f", {14'h0, fatal, nfatal}, 16'h0001);
    // flooding needs the report enable on a slave
    wr(8'h48, 16'h0003);
    w3();
    chk("flood_unq", {15'h0, flood}, 16'h0000);
    rep_en <= 1'b1;
    w3();
    chk("flood_prot", {14'h0, flood, cfail}, 16'h0003);
    cmd <= 6'h02;
    w3();
    chk("flood_ovfl", {15'h0, flood}, 16'h0001);
    cmd <= 6'h00;
    rep_en <= 1'b0;
    w3();
    chk("flood_off", {14'h0, flood, cfail}, 16'h0001);
    chain <= 1'b1;
    @(posedge clk_i);
    chain <= 1'b0;
    w3();
    chk("cfail_clr", {15'h0, cfail}, 16'h0000);
    rdc("ctl_keep", 8'h48, 16'h0003);
    sflood <= 1'b1;
    @(posedge clk_i);
    sflood <= 1'b0;
    rdc("ctl_cfail", 8'h48, 16'h0103);
    // plain registers, read-only and unmapped places
    wr(8'h40, 16'ha5c3);
    wr(8'h50, 16'h005a);
    wr(8'h54, 16'h00c3);
    wr(8'h68, 16'h00ff);
    wr(8'h7c, 16'hffff);
    cfgbus <= 8'h3c;
    cfgwr <= 1'b1;
    @(posedge clk_i);
    cfgwr <= 1'b0;
    rdc("scr", 8'h40, 16'ha5c3);
    // high lane only: the low byte must survive
    lanes = 4'h2;
    wr(8'h40, 16'h1234);
    lanes = 4'h3;
    rdc("scr_lane", 8'h40, 16'h12c3);
    rdc("base", 8'h50, 16'h005a);
    rdc("limit", 8'h54, 16'h00c3);
    rdc("bus", 8'h68, 16'h003c);
    rdc("unmapped", 8'h7c, 16'h0000);
    chk("ext_own", {base_o, limit_o}, 16'h5ac3);
    chk("bus_o", {8'h0, bus_o}, 16'h003c);
    pbase <= 8'h11;
    plimit <= 8'h22;
    useprim <= 1'b1;
    w3();
    chk("ext_prim", {base_o, limit_o}, 16'h1122);
    useprim <= 1'b0;
    // warm reset keeps the scratchpad, cold clears it
    pulse_reset(1'b0);
    rdc("scr_warm", 8'h40, 16'h12c3);
    rdc("ctl_warm", 8'h48, 16'h0000);
    rdc("base_warm", 8'h50, 16'h0000);
    rdc("bus_warm", 8'h68, 16'h0000);
    pulse_reset(1'b1);
    rdc("scr_cold", 8'h40, 16'h0000);
    final_report();
  end
endmodule
